/* src/scp_top.sv */
// Switching clock sourcing, sync pin control and phase spreading
// What this block does
// RULE1: Sync output with hold option keeps running 500 ms after disable, then stops.
// RULE2: With exact ramp delay active, hold option ignored; sync runs on forever.
// RULE3: Internal oscillator period follows the written frequency setpoint.
// RULE4: Host sets the setpoint equal to any external clock it applies.
// RULE5: Frequency readback is the quantised period, may differ from setpoint.
// RULE6: Spread word: 15:12 unused, 11:8 label, 7:4 size, 3:0 slot.
// RULE7: Group label never influences the phase offset.
// RULE8: Offset fraction equals slot index over group size of the period.
// RULE9: Group size zero counts as sixteen.
// RULE10: All participating regulators must share one common switching clock.
// RULE11: In a share group the offset is assigned automatically.
// RULE12: Spread word shift adds on top of the automatic share offset.
// RULE13: Offsets rounded to nearest of sixteen 22.5 degree steps.
// RULE14: Host order: defaults, sync pins, spreading, general, save.
// RULE15: Hold option clear: sync output keeps running after disable.
// RULE16: Auto mode checks for sync clock at enable, else runs freely.
// RULE17: Offset measured from the rising edge of the common sync clock.
// RULE18: New spread word takes effect at the next period boundary.
module scp_top #(
  parameter int unsigned HOLD_CYCLES = scp_pkg::HOLD_CYC
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             link_clk_i,
  input  wire logic [1:0]       sync_mode_i,
  input  wire logic             sync_push_pull_i,
  input  wire logic             hold_opt_i,
  input  wire logic             exact_ramp_off_i,
  input  wire logic             out_enable_i,
  input  wire logic [15:0]      freq_khz_i,
  input  wire logic             freq_wr_i,
  input  wire logic [15:0]      spread_wdata_i,
  input  wire logic             spread_wr_i,
  input  wire logic [3:0]       share_step_i,
  input  wire logic             share_member_i,
  input  wire logic             sync_in_i,
  output logic                  sync_out_o,
  output logic                  sync_oe_b_o,
  output logic [15:0]           spread_rdata_o,
  output logic [15:0]           freq_meas_khz_o,
  output logic                  sw_edge_o,
  output logic                  ext_locked_o
);

  localparam int unsigned KHZ_PER_MHZ = 1000;

  // ==========================================================================
  // Register state
  logic [15:0] spread_reg;
  logic [15:0] freq_reg;
  logic [15:0] period_reg;
  logic [15:0] period_next;

  // Period in clk_i cycles: 100 MHz / f; quantised to whole cycles
  function automatic logic [15:0] khz_to_cycles(input logic [15:0] khz);
    logic [31:0] q;
    q = (khz == 16'h0000) ? 32'h0000_FFFF :
        (32'(scp_pkg::CLK_MHZ) * 32'(KHZ_PER_MHZ)) / {16'h0000, khz};
    khz_to_cycles = (q > 32'h0000_FFFF) ? 16'hFFFF :
                    (q < 32'h0000_0002) ? 16'h0002 : q[15:0];
  endfunction : khz_to_cycles

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      freq_reg <= scp_pkg::FREQ_KHZ_RST;
    end else if (freq_wr_i) begin
      freq_reg <= freq_khz_i;                   // see RULE3
    end
  end

  assign period_next = khz_to_cycles(freq_reg);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      spread_reg <= scp_pkg::SPREAD_RST;
    end else if (spread_wr_i) begin
      spread_reg <= spread_wdata_i;
    end
  end

  assign spread_rdata_o = spread_reg;

  // ==========================================================================
  // Crossing of the sync pin into clk_i domain
  logic [1:0] sync_ff;
  logic       sync_d;
  logic       sync_rise;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_ff <= 2'b00;
      sync_d  <= 1'b0;
    end else begin
      sync_ff <= {sync_ff[0], sync_in_i};
      sync_d  <= sync_ff[1];
    end
  end

  assign sync_rise = sync_ff[1] & ~sync_d;

  // Link-side activity detector: toggles each external rising edge
  logic link_tog;
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      link_tog <= 1'b0;
    end else begin
      link_tog <= ~link_tog;
    end
  end

  logic [2:0] tog_ff;
  logic       link_evt;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tog_ff <= 3'b000;
    end else begin
      tog_ff <= {tog_ff[1:0], link_tog};
    end
  end
  assign link_evt = tog_ff[2] ^ tog_ff[1];

  // ==========================================================================
  // Clock source selection at enable
  scp_pkg::scp_src_e src_reg;
  logic [10:0]       det_cnt_reg;
  logic              en_d;
  logic              en_rise;
  logic              clk_seen;
  scp_pkg::scp_mode_e mode;

  assign mode     = scp_pkg::scp_mode_e'(sync_mode_i);
  assign clk_seen = sync_rise | link_evt;
  assign en_rise  = out_enable_i & ~en_d;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      en_d <= 1'b0;
    end else begin
      en_d <= out_enable_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      src_reg     <= scp_pkg::SCP_SRC_IDLE;
      det_cnt_reg <= 11'h000;
    end else begin
      case (src_reg)
        scp_pkg::SCP_SRC_IDLE: begin
          det_cnt_reg <= 11'h000;
          if (en_rise) begin
            if (mode == scp_pkg::SCP_MODE_OUTPUT) begin
              src_reg <= scp_pkg::SCP_SRC_INT;
            end else begin
              src_reg <= scp_pkg::SCP_SRC_DETECT; // see RULE16
            end
          end
        end
        scp_pkg::SCP_SRC_DETECT: begin
          det_cnt_reg <= det_cnt_reg + 11'h001;
          if (clk_seen) begin
            src_reg <= scp_pkg::SCP_SRC_EXT;
          end else if (det_cnt_reg == 11'(scp_pkg::DETECT_CYC)) begin
            // Input mode waits on; auto falls back to free running
            if (mode == scp_pkg::SCP_MODE_AUTO) begin
              src_reg <= scp_pkg::SCP_SRC_INT;    // see RULE16
            end else begin
              det_cnt_reg <= 11'h000;
            end
          end
        end
        scp_pkg::SCP_SRC_EXT,
        scp_pkg::SCP_SRC_INT: begin
          if (!out_enable_i && mode != scp_pkg::SCP_MODE_OUTPUT) begin
            src_reg <= scp_pkg::SCP_SRC_IDLE;
          end
        end
        default: begin
          src_reg <= scp_pkg::SCP_SRC_IDLE;
        end
      endcase
    end
  end

  assign ext_locked_o = (src_reg == scp_pkg::SCP_SRC_EXT);

  // ==========================================================================
  // Oscillator: period counter restarts on external rising edge when locked, else at the end of the period
  logic [15:0] ph_cnt_reg;
  logic        boundary;

  assign boundary = ext_locked_o ? sync_rise :
                    (ph_cnt_reg >= period_reg - 16'h0001);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ph_cnt_reg <= 16'h0000;
    end else if (boundary) begin
      ph_cnt_reg <= 16'h0000;                   // see RULE17
    end else begin
      ph_cnt_reg <= ph_cnt_reg + 16'h0001;
    end
  end

  // Period and spread step only change at a boundary, so no short pulse
  logic [3:0] step_reg;
  logic [3:0] step_next;

  scp_phase_quant u_quant (
    .slot_i      (spread_reg[scp_pkg::SLOT_LSB +: scp_pkg::FIELD_W]),
    .size_i      (spread_reg[scp_pkg::SIZE_LSB +: scp_pkg::FIELD_W]),
    .auto_step_i (share_member_i ? share_step_i : 4'h0),
    .step_o      (step_next)
  );
  // Label bits 11:8 are stored but never reach the quantiser; see RULE7
  // Field decode of the spread word above; see RULE6 RULE8 RULE9 RULE13
  // Share-group automatic step added under the shift; see RULE11 RULE12

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      step_reg   <= 4'h0;
      period_reg <= 16'h0002;
    end else if (boundary) begin
      step_reg   <= step_next;                  // see RULE18
      period_reg <= period_next;
    end
  end

  // Edge time = step * period / 16, computed once per boundary value
  logic [19:0] edge_prod;
  logic [15:0] edge_at;
  assign edge_prod = {16'h0000, step_reg} * {4'h0, period_reg};
  assign edge_at   = edge_prod[19:4];

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sw_edge_o <= 1'b0;
    end else begin
      sw_edge_o <= out_enable_i && (src_reg == scp_pkg::SCP_SRC_INT ||
                   src_reg == scp_pkg::SCP_SRC_EXT) &&
                   (boundary ? (edge_at == 16'h0000)
                             : (ph_cnt_reg + 16'h0001 == edge_at));
    end
  end

  // Frequency readback is from the quantised period actually used
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      freq_meas_khz_o <= 16'h0000;
    end else begin
      freq_meas_khz_o <= khz_to_cycles(period_reg);  // see RULE5
    end
  end

  // ==========================================================================
  // Sync output drive and hold after disable
  logic [31:0] hold_cnt_reg;
  logic        drive_on;
  logic        timed_hold;

  assign timed_hold = hold_opt_i & exact_ramp_off_i;   // see RULE2 RULE15

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_cnt_reg <= 32'h0000_0000;
    end else if (out_enable_i || !timed_hold) begin
      hold_cnt_reg <= 32'h0000_0000;
    end else if (hold_cnt_reg < HOLD_CYCLES) begin
      hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;    // see RULE1
    end
  end

  assign drive_on = (mode == scp_pkg::SCP_MODE_OUTPUT) &&
                    (out_enable_i || !timed_hold ||
                     hold_cnt_reg < HOLD_CYCLES);       // see RULE1

  logic osc_lvl;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_lvl <= 1'b0;
    end else begin
      osc_lvl <= (ph_cnt_reg < {1'b0, period_reg[15:1]});
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_out_o  <= 1'b0;
      sync_oe_b_o <= 1'b1;
    end else begin
      sync_out_o  <= drive_on & osc_lvl;
      // Open drain only pulls low; push-pull drives both levels
      sync_oe_b_o <= ~(drive_on & (sync_push_pull_i | ~osc_lvl));
    end
  end

  // ==========================================================================
  // Assertions
  a_hold_stops: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == scp_pkg::SCP_MODE_OUTPUT && timed_hold && !out_enable_i &&
     hold_cnt_reg >= HOLD_CYCLES) |-> ##1 (sync_oe_b_o && !sync_out_o)) // see RULE1
    else $error("sync output still driven after hold time");

  a_exact_forever: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == scp_pkg::SCP_MODE_OUTPUT && !exact_ramp_off_i) |-> drive_on) // see RULE2
    else $error("sync output stopped while exact ramp mode active");

  a_default_on: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == scp_pkg::SCP_MODE_OUTPUT && !hold_opt_i) |-> drive_on) // see RULE15
    else $error("sync output stopped with hold option clear");

  a_no_drive_in: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode != scp_pkg::SCP_MODE_OUTPUT) |=> sync_oe_b_o)
    else $error("sync pin driven while not an output");

  a_step_boundary: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !$past(boundary) |-> $stable(step_reg)) // see RULE18
    else $error("phase step changed away from a period boundary");

  a_auto_fallback: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (src_reg == scp_pkg::SCP_SRC_DETECT && mode == scp_pkg::SCP_MODE_AUTO &&
     det_cnt_reg == 11'(scp_pkg::DETECT_CYC) && !clk_seen)
    |=> src_reg == scp_pkg::SCP_SRC_INT) // see RULE16
    else $error("auto mode did not fall back to internal oscillator");

  a_ext_align: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ext_locked_o && sync_rise) |=> ph_cnt_reg == 16'h0000) // see RULE17
    else $error("phase counter not aligned to sync rising edge");

  a_period_tracks: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    boundary |=> period_reg == $past(period_next)) // see RULE3
    else $error("oscillator period does not follow setpoint");

  a_zero_slot: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (boundary && step_reg == 4'h0 && out_enable_i && ext_locked_o)
    |=> sw_edge_o) // see RULE17
    else $error("slot zero edge not at sync boundary");

endmodule : scp_top

/* src/scp_pkg.sv */
// Constants and types shared by the switching clock phase spreader
package scp_pkg;

  // ==========================================================================
  // Phase spread word layout
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned SLOT_LSB    = 0;
  localparam int unsigned SIZE_LSB    = 4;
  localparam int unsigned LABEL_LSB   = 8;
  localparam int unsigned FIELD_W     = 4;
  localparam logic [15:0] SPREAD_RST  = 16'h0000;

  // ==========================================================================
  // Oscillator and timing
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned HOLD_MS        = 500;
  localparam int unsigned HOLD_CYC       = HOLD_MS * 1000 * CLK_MHZ;
  localparam int unsigned PER_W          = 16;
  localparam logic [15:0] FREQ_KHZ_RST   = 16'h0190;
  // Timeout for detecting an incoming sync edge, in clk_i cycles
  localparam int unsigned DETECT_CYC     = 1024;
  localparam int unsigned STEPS          = 16;

  // ==========================================================================
  // Sync pin modes
  typedef enum logic [1:0] {
    SCP_MODE_AUTO,
    SCP_MODE_INPUT,
    SCP_MODE_OUTPUT
  } scp_mode_e;

  typedef enum logic [1:0] {
    SCP_SRC_IDLE,
    SCP_SRC_DETECT,
    SCP_SRC_EXT,
    SCP_SRC_INT
  } scp_src_e;

endpackage : scp_pkg

/* src/scp_phase_quant.sv */
// Rounds a slot/size ratio to one of sixteen phase steps
module scp_phase_quant (
  input  wire logic [3:0] slot_i,
  input  wire logic [3:0] size_i,
  input  wire logic [3:0] auto_step_i,
  output logic      [3:0] step_o
);

  logic [4:0] size_eff;
  logic [9:0] num;
  logic [9:0] quo;
  logic [3:0] spread_step;

  always_comb begin
    size_eff    = (size_i == 4'h0) ? 5'h10 : {1'b0, size_i}; // see RULE9
    // Round to nearest: (16*slot + size/2) / size
    num         = {2'b00, slot_i, 4'h0} + {6'h00, size_eff[4:1]};
    quo         = num / {5'h00, size_eff};             // see RULE8 RULE13
    spread_step = quo[3:0];
    // Shift stacks on the share-group position, keeping member spacing
    step_o      = spread_step + auto_step_i;           // see RULE12
  end

endmodule : scp_phase_quant

/* dv/scp_sync_peer.sv */
// Neighbouring regulator that can source the shared sync clock
module scp_sync_peer (
  input  wire logic run_i,
  output logic      clk_o,
  output logic      oe_b_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Sync source
  // Clock stands still low outside sourcing; odd start keeps phase unrelated
  initial begin
    clk_o = 1'b0;
    #7;
    forever begin
      #24;
      clk_o = run_i ? ~clk_o : 1'b0;
    end
  end

  // Line is released whenever this regulator is not sourcing
  assign oe_b_o = ~run_i;
endmodule : scp_sync_peer

/* dv/scp_top_test.sv */
// Self-checking bench for the sync clock phase spreader
module scp_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals
  logic        clk_i, rst_b_i, hold, ramp_off, en, fwr, swr, pp;
  logic        member, peer_run, sync_out, oe_b, sw_edge, locked;
  logic        peer_clk, peer_oe_b, sync_line;
  logic [1:0]  mode;
  logic [3:0]  share;
  logic [15:0] fkhz, wdata, rdata, fmeas;
  int          err_count, tests_run, d0, d, n;
  logic [15:0] tw [8] = '{16'h0031, 16'h0032, 16'h0F31, 16'h0001,
                          16'h0061, 16'h0021, 16'h0000, 16'h0021};
  logic [3:0]  ts [8] = '{4'h5, 4'hB, 4'h5, 4'h1, 4'h3, 4'h8, 4'h5, 4'hD};

  // Pull-up holds the line high when nobody drives it
  assign sync_line = !oe_b ? sync_out : (!peer_oe_b ? peer_clk : 1'b1);

  scp_top #(.HOLD_CYCLES(200)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .link_clk_i(peer_clk),
    .sync_mode_i(mode), .sync_push_pull_i(pp), .hold_opt_i(hold),
    .exact_ramp_off_i(ramp_off), .out_enable_i(en), .freq_khz_i(fkhz),
    .freq_wr_i(fwr), .spread_wdata_i(wdata), .spread_wr_i(swr),
    .share_step_i(share), .share_member_i(member), .sync_in_i(sync_line),
    .sync_out_o(sync_out), .sync_oe_b_o(oe_b), .spread_rdata_o(rdata),
    .freq_meas_khz_o(fmeas), .sw_edge_o(sw_edge), .ext_locked_o(locked)
  );

  scp_sync_peer peer (.run_i(peer_run), .clk_o(peer_clk), .oe_b_o(peer_oe_b));

  initial begin
    clk_i = 1'b0;
    forever begin
      #5 clk_i = ~clk_i;
    end
  end

  // ==========================================================================
  // Tasks
  task automatic chk16(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk16

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask : cyc

  task automatic wr_spread(input logic [15:0] w);
    @(posedge clk_i);
    wdata <= w;
    swr   <= 1'b1;
    @(posedge clk_i);
    swr   <= 1'b0;
  endtask : wr_spread

  task automatic wr_freq(input logic [15:0] f);
    @(posedge clk_i);
    fkhz <= f;
    fwr  <= 1'b1;
    @(posedge clk_i);
    fwr  <= 1'b0;
  endtask : wr_freq

  // Cycles from a sync output rise to the next switching edge
  task automatic meas(output int k);
    int m;
    m = 0;
    k = 99;
    @(negedge clk_i);
    while (sync_out !== 1'b0 && m < 64) begin
      @(negedge clk_i);
      m++;
    end
    while (sync_out !== 1'b1 && m < 128) begin
      @(negedge clk_i);
      m++;
    end
    for (int i = 0; i < 32 && k == 99; i++) begin
      if (sw_edge === 1'b1) begin
        k = i;
      end
      @(negedge clk_i);
    end
  endtask : meas

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // One auto-detect timeout plus hold waits stay well below this
  initial begin
    #200us;
    err_count++;
    tally_and_finish();
  end

  // ==========================================================================
  // Tests
  initial begin
    err_count = 0;
    tests_run = 0;
    {rst_b_i, hold, ramp_off, en, fwr, swr, pp, member, peer_run} = '0;
    mode  = 2'h0;
    share = 4'h5;
    fkhz  = 16'h0000;
    wdata = 16'h0000;
    cyc(6);
    chk16("oe_b_rst", 16'h0001, {15'h0, oe_b});
    chk16("spread_rst", 16'h0000, rdata);
    rst_b_i <= 1'b1;
    cyc(10);
    chk16("fmeas_rst", 16'h0190, fmeas);
    wr_spread(16'h0F32);
    cyc(2);
    chk16("spread", 16'h0F32, rdata);
    wr_freq(16'h1B58);
    cyc(300);
    chk16("fmeas_q", 16'h1BE6, fmeas);
    wr_freq(16'h186A);
    cyc(40);
    chk16("fmeas", 16'h186A, fmeas);
    mode <= 2'h2;
    pp   <= 1'b1;
    en   <= 1'b1;
    wr_spread(16'h0030);
    cyc(48);
    meas(d0);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      member <= (i >= 6);
      wr_spread(tw[i]);
      cyc(48);
      meas(d);
      chk16("offset", 16'((d0 + ts[i]) % 16), 16'(d));
    end
    @(posedge clk_i);
    member   <= 1'b0;
    hold     <= 1'b1;
    ramp_off <= 1'b1;
    en       <= 1'b0;
    cyc(150);
    chk16("hold_on", 16'h0000, {15'h0, oe_b});
    cyc(100);
    chk16("hold_off", 16'h0001, {15'h0, oe_b});
    for (int i = 0; i < 2; i++) begin
      hold     <= (i == 0);
      ramp_off <= (i == 1);
      en       <= 1'b1;
      cyc(10);
      en <= 1'b0;
      cyc(260);
      chk16("sync_kept", 16'h0000, {15'h0, oe_b});
    end
    // Open drain must release the line while the clock level is high
    pp <= 1'b0;
    cyc(20);
    @(negedge clk_i iff sync_out === 1'b1);
    chk16("od_high", 16'h0001, {15'h0, oe_b});
    @(posedge clk_i);
    mode     <= 2'h1;
    peer_run <= 1'b1;
    wr_freq(16'h5161);
    cyc(20);
    en <= 1'b1;
    cyc(300);
    chk16("ext_lock", 16'h0001, {15'h0, locked});
    chk16("in_oe_b", 16'h0001, {15'h0, oe_b});
    en       <= 1'b0;
    peer_run <= 1'b0;
    mode     <= 2'h0;
    cyc(20);
    en <= 1'b1;
    cyc(1200);
    chk16("free_run", 16'h0000, {15'h0, locked});
    n = 0;
    repeat (64) begin
      @(negedge clk_i);
      n += (sw_edge === 1'b1);
    end
    chk16("free_edges", 16'h0001, {15'h0, n > 0});
    @(posedge clk_i);
    en       <= 1'b0;
    peer_run <= 1'b1;
    cyc(20);
    en <= 1'b1;
    cyc(300);
    chk16("auto_lock", 16'h0001, {15'h0, locked});
    tally_and_finish();
  end
endmodule : scp_top_test
